// *** src/tccpt_channel.sv ***
`default_nettype none
module tccpt_channel
    import tccpt_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire tccpt_chctl_t ctl,
    input  wire logic         pin_in,
    input  wire logic [15:0]  counter,
    input  wire logic         tick,
    input  wire logic [15:0]  compare_value,
    output logic              capture,
    output logic              match
);
    logic prev_pin;
    logic rise;
    logic fall;
    logic is_capture;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_pin <= 1'b0;
        end else begin
            prev_pin <= pin_in;
        end
    end

    always_comb begin
        rise       = pin_in & ~prev_pin;
        fall       = ~pin_in & prev_pin;
        is_capture = ~ctl.channel_mode_b & ~ctl.channel_mode_a;
        capture    = 1'b0;
        if (is_capture) begin
            unique case ({ctl.edge_level_select_b, ctl.edge_level_select_a})
                ELS_RISE: capture = rise;
                ELS_FALL: capture = fall;
                ELS_ANY:  capture = rise | fall;
                default:  capture = 1'b0;
            endcase
        end
        match = ~is_capture & tick & (counter == compare_value);
    end
endmodule : tccpt_channel
`default_nettype wire

// *** src/tccpt_pkg.sv ***
// What this block does
// - one 16-bit up-counter, free-running or wrapping at a modulo limit
// - modulo limit comes from the single 16-bit counter_limit field
// - counter value readable any time without disturbing counting
// - two channels, each capture or compare independently
// - seven prescaled rates from bus clock, picked by three-bit select
// - active edge on capture pin copies counter into channel value
// - capture event may request interrupt when channel enable set
// - compare match sets, clears or toggles channel pin
// - compare match may request interrupt when channel enable set
// - unbuffered value write takes effect at once, no shadow
// - channel0 mode b links channels into buffered output on pin 0
// - linked: channel 0 first, then most recently written set after overflow
// - linked: only channel 0 control applies, channel 1 control ignored
// - linked: channel 1 pin released to general-purpose use
// - toggle-on-overflow inverts pin at each overflow
// - pulse width is overflow to compare match interval
// - period is modulo plus one ticks; 0x00ff gives 256 clocks
// - duty is compare over period; 0x0080 of 0x00ff is half
// - counter at limit rolls to zero next tick and sets overflow flag
// - mode pair 0:1 unbuffered compare, 1:0 buffered compare
// - edge/level pair 1:0 clears, 1:1 sets pin on compare
// - toggle-on-overflow clear gives 0 duty; with it clear, max duty bit gives 100 percent
`default_nettype none
package tccpt_pkg;
    localparam int          CNT_W       = 16;
    localparam logic [15:0] LIMIT_RESET = 16'hffff;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [2:0]  PS_MAX      = 3'h6;
    localparam logic [1:0]  ELS_NONE    = 2'h0;
    localparam logic [1:0]  ELS_TOGGLE  = 2'h1;
    localparam logic [1:0]  ELS_CLEAR   = 2'h2;
    localparam logic [1:0]  ELS_SET     = 2'h3;
    localparam logic [1:0]  ELS_RISE    = 2'h1;
    localparam logic [1:0]  ELS_FALL    = 2'h2;
    localparam logic [1:0]  ELS_ANY     = 2'h3;

    typedef struct packed {
        logic       int_enable;
        logic       channel_mode_b;
        logic       channel_mode_a;
        logic       edge_level_select_b;
        logic       edge_level_select_a;
        logic       toggle_on_overflow;
        logic       channel_max_duty;
    } tccpt_chctl_t;

    typedef struct packed {
        logic        stop;
        logic        counter_reset;
        logic        ovf_int_enable;
        logic [2:0]  prescaler_select;
        logic [15:0] counter_limit;
    } tccpt_ctl_t;
endpackage : tccpt_pkg
`default_nettype wire

// *** src/tccpt_prescaler.sv ***
`default_nettype none
module tccpt_prescaler
    import tccpt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [2:0] prescaler_select,
    output logic            tick
);
    typedef struct packed {
        logic [5:0] div;
        logic       tick;
    } tccpt_ps_state_t;

    tccpt_ps_state_t st, next_st;
    logic [2:0] sel;

    always_comb begin
        next_st = st;
        sel     = (prescaler_select > PS_MAX) ? PS_MAX : prescaler_select;
        next_st.tick = 1'b0;
        if (clear) begin
            next_st.div = '0;
        end else if (run) begin
            next_st.div = st.div + 6'h01;
            // tick on wrap of the selected divider bit range, seven rates
            next_st.tick = (st.div & ((6'h01 << sel) - 6'h01)) == ((6'h01 << sel) - 6'h01);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : tccpt_prescaler
`default_nettype wire

// *** src/tccpt_timer.sv ***
`default_nettype none
module tccpt_timer
    import tccpt_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire tccpt_ctl_t   ctl,
    input  wire tccpt_chctl_t ch0_ctl,
    input  wire tccpt_chctl_t ch1_ctl,
    input  wire logic [15:0]  ch0_wdata,
    input  wire logic         ch0_write,
    input  wire logic [15:0]  ch1_wdata,
    input  wire logic         ch1_write,
    input  wire logic         overflow_flag_clear,
    input  wire logic         ch0_flag_clear,
    input  wire logic         ch1_flag_clear,
    input  wire logic         channel0_pin_in,
    input  wire logic         channel1_pin_in,
    output logic [15:0]       counter,
    output logic [15:0]       ch0_value,
    output logic [15:0]       ch1_value,
    output logic              overflow_flag,
    output logic              ch0_flag,
    output logic              ch1_flag,
    output logic              overflow_irq,
    output logic              ch0_irq,
    output logic              ch1_irq,
    output logic              channel0_pin_out,
    output logic              channel0_pin_oe,
    output logic              channel1_pin_out,
    output logic              channel1_pin_oe,
    output logic              channel1_released
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] val0;
        logic [15:0] val1;
        logic        ovf_f;
        logic        f0;
        logic        f1;
        logic        ovf_irq;
        logic        irq0;
        logic        irq1;
        logic        pin0;
        logic        pin1;
        logic        oe0;
        logic        oe1;
        logic        linked;
        logic        active1;
        logic        pend1;
        logic        pend_valid;
    } tccpt_state_t;

    tccpt_state_t st, next_st;

    logic tick;
    logic cap0, cap1, m0, m1;
    logic wrap;
    logic [15:0] cmp0;
    logic [15:0] cnt_next;
    tccpt_chctl_t eff1;

    tccpt_prescaler u_prescaler (
        .sys_clk          (sys_clk),
        .reset            (reset),
        .clear            (ctl.counter_reset),
        .run              (~ctl.stop),
        .prescaler_select (ctl.prescaler_select),
        .tick             (tick)
    );

    // linked pair: compare uses whichever value set currently owns pin 0
    assign cmp0 = (st.linked && st.active1) ? st.val1 : st.val0;
    assign eff1 = st.linked ? '0 : ch1_ctl;

    assign wrap     = tick && (st.cnt == ctl.counter_limit);
    // compare sees the count this tick lands on, so the pin moves with the
    // count and a width of v lasts exactly v ticks
    assign cnt_next = (ctl.counter_reset || wrap) ? CNT_ZERO : st.cnt + 16'h0001;

    tccpt_channel u_ch0 (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .ctl           (ch0_ctl),
        .pin_in        (channel0_pin_in),
        .counter       (cnt_next),
        .tick          (tick),
        .compare_value (cmp0),
        .capture       (cap0),
        .match         (m0)
    );

    tccpt_channel u_ch1 (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .ctl           (eff1),
        .pin_in        (channel1_pin_in),
        .counter       (cnt_next),
        .tick          (tick),
        .compare_value (st.val1),
        .capture       (cap1),
        .match         (m1)
    );

    always_comb begin
        next_st = st;

        // counter: plain up count, wraps at limit; read path is a copy
        if (ctl.counter_reset) begin
            next_st.cnt = CNT_ZERO;
        end else if (tick) begin
            next_st.cnt = cnt_next;
        end

        next_st.linked = ch0_ctl.channel_mode_b;

        // value registers: writes land directly, no shadow
        if (ch0_write) begin
            next_st.val0 = ch0_wdata;
        end else if (cap0) begin
            next_st.val0 = st.cnt;
        end
        if (ch1_write) begin
            next_st.val1 = ch1_wdata;
        end else if (cap1) begin
            next_st.val1 = st.cnt;
        end

        // most recent write picks the set that takes over at overflow
        if (ch0_write) begin
            next_st.pend1      = 1'b0;
            next_st.pend_valid = 1'b1;
        end
        if (ch1_write) begin
            next_st.pend1      = 1'b1;
            next_st.pend_valid = 1'b1;
        end
        if (!st.linked) begin
            next_st.active1    = 1'b0;
            next_st.pend_valid = 1'b0;
        end else if (wrap && st.pend_valid) begin
            next_st.active1    = st.pend1;
            next_st.pend_valid = ch0_write | ch1_write;
        end

        // sticky flags: set wins over clear
        next_st.ovf_f = wrap | (st.ovf_f & ~overflow_flag_clear);
        next_st.f0    = cap0 | m0 | (st.f0 & ~ch0_flag_clear);
        next_st.f1    = ((cap1 | m1) & ~st.linked) | (st.f1 & ~ch1_flag_clear);
        next_st.ovf_irq = next_st.ovf_f & ctl.ovf_int_enable;
        next_st.irq0    = next_st.f0 & ch0_ctl.int_enable;
        next_st.irq1    = next_st.f1 & eff1.int_enable;

        // channel 0 pin
        next_st.oe0  = ch0_ctl.channel_mode_b | ch0_ctl.channel_mode_a;
        next_st.pin0 = pin_action(st.pin0, ch0_ctl, m0, wrap);

        // channel 1 pin, released when linked
        // drop the drive on the same edge the link shows, not one later
        next_st.oe1  = ~ch0_ctl.channel_mode_b & ~st.linked
                       & (eff1.channel_mode_b | eff1.channel_mode_a);
        next_st.pin1 = pin_action(st.pin1, eff1, m1, wrap);
        if (st.linked) begin
            next_st.pin1 = 1'b0;
        end
    end

    function automatic logic pin_action(
        input logic         cur,
        input tccpt_chctl_t c,
        input logic         match,
        input logic         ovf
    );
        logic v;
        v = cur;
        if (c.channel_mode_b | c.channel_mode_a) begin
            // overflow toggles first, then a same-tick compare overrides
            if (ovf && c.toggle_on_overflow) begin
                v = ~v;
            end
            if (match) begin
                unique case ({c.edge_level_select_b, c.edge_level_select_a})
                    ELS_TOGGLE: v = ~cur;
                    ELS_CLEAR:  v = 1'b0;
                    ELS_SET:    v = 1'b1;
                    ELS_NONE:   v = v;
                endcase
            end
            // 100 percent duty only without toggle; clear tov alone gives 0
            if (c.channel_max_duty && !c.toggle_on_overflow) begin
                v = (c.edge_level_select_a) ? 1'b0 : 1'b1;
            end
        end
        pin_action = v;
    endfunction : pin_action

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign counter           = st.cnt;
    assign ch0_value         = st.val0;
    assign ch1_value         = st.val1;
    assign overflow_flag     = st.ovf_f;
    assign ch0_flag          = st.f0;
    assign ch1_flag          = st.f1;
    assign overflow_irq      = st.ovf_irq;
    assign ch0_irq           = st.irq0;
    assign ch1_irq           = st.irq1;
    assign channel0_pin_out  = st.pin0;
    assign channel0_pin_oe   = st.oe0;
    assign channel1_pin_out  = st.pin1;
    assign channel1_pin_oe   = st.oe1;
    assign channel1_released = st.linked;
endmodule : tccpt_timer
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top
    import tccpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, ch0_write, ch1_write, overflow_flag_clear, ch0_flag_clear;
    logic ch1_flag_clear, overflow_flag, ch0_flag, ch1_flag, overflow_irq, ch0_irq, ch1_irq;
    logic channel0_pin_out, channel0_pin_oe, channel1_pin_out, channel1_pin_oe, released;
    logic [15:0] counter, ch0_value, ch1_value, ch0_wdata, ch1_wdata, c, v;
    logic [1:0] ext, pin;
    logic [31:0] seed;
    tccpt_ctl_t ctl;
    tccpt_chctl_t ch0_ctl, ch1_ctl;
    int failures, checks, cycles, hi;

    tccpt_timer DUT (.sys_clk(sys_clk), .reset(reset), .ctl(ctl), .ch0_ctl(ch0_ctl),
        .ch1_ctl(ch1_ctl), .ch0_wdata(ch0_wdata), .ch0_write(ch0_write),
        .ch1_wdata(ch1_wdata), .ch1_write(ch1_write), .overflow_flag_clear(overflow_flag_clear),
        .ch0_flag_clear(ch0_flag_clear), .ch1_flag_clear(ch1_flag_clear),
        .channel0_pin_in(pin[0]), .channel1_pin_in(pin[1]), .counter(counter),
        .ch0_value(ch0_value), .ch1_value(ch1_value), .overflow_flag(overflow_flag),
        .ch0_flag(ch0_flag), .ch1_flag(ch1_flag), .overflow_irq(overflow_irq),
        .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .channel0_pin_out(channel0_pin_out),
        .channel0_pin_oe(channel0_pin_oe), .channel1_pin_out(channel1_pin_out),
        .channel1_pin_oe(channel1_pin_oe), .channel1_released(released));
    tccpt_pin_model u_pins (.sys_clk(sys_clk), .ext(ext), .pin(pin),
        .out({channel1_pin_out, channel0_pin_out}), .oe({channel1_pin_oe, channel0_pin_oe}));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int width(input logic [1:0] els, input logic [15:0] lim,
                                 input logic [15:0] v);
        return (els == ELS_CLEAR) ? int'(v) : int'(lim) + 1 - int'(v);
    endfunction : width
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic hicount(input int n);
        hi = 0;
        repeat (n) begin
            @(negedge sys_clk);
            hi += int'(channel0_pin_out === 1'b1);
        end
    endtask : hicount
    // stop, clear and program in the same cycle, then release, so the first period starts clean
    task automatic pwm(input logic [2:0] sel, input logic [1:0] els, input logic [15:0] lim,
                       input logic [15:0] v, input logic lnk);
        int per;
        per = (int'(lim) + 1) << sel;
        @(posedge sys_clk);
        ctl.stop <= 1'b1;
        ctl.counter_reset <= 1'b1;
        ctl.counter_limit <= lim;
        ctl.prescaler_select <= sel;
        ch0_wdata <= v;
        ch0_write <= 1'b1;
        ch0_ctl <= '{1'b1, lnk, !lnk, els[1], els[0], 1'b1, 1'b0};
        @(posedge sys_clk);
        ch0_write <= 1'b0;
        ctl.stop <= 1'b0;
        ctl.counter_reset <= 1'b0;
        hicount(2 * per);
        hicount(3 * per);
        chk("pulse width", 32'(hi), 32'((3 * width(els, lim, v)) << sel));
    endtask : pwm

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge sys_clk);
            cycles++;
            if (cycles == 40000) begin
                failures++;
                tally_and_finish();
            end
        end
    end
    initial begin
        failures = 0;
        checks = 0;
        seed = 32'hb3edf284;
        reset = 1'b1;
        ctl = '{1'b1, 1'b0, 1'b1, 3'h0, LIMIT_RESET};
        ch0_ctl = '0;
        ch1_ctl = '0;
        {ch0_write, ch1_write, overflow_flag_clear, ch0_flag_clear, ch1_flag_clear} = '0;
        ch0_wdata = '0;
        ch1_wdata = '0;
        ext = 2'b00;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk("reset state", 32'({counter, overflow_flag, ch0_flag, channel0_pin_oe}), 32'h0);
        pwm(3'h0, ELS_CLEAR, 16'h00ff, 16'h0080, 1'b0);
        chk("flags", 32'({overflow_flag, overflow_irq, ch0_flag, ch0_irq}), 32'hf);
        chk("channel 0 value", 32'(ch0_value), 32'h0080);
        @(posedge sys_clk);
        ch0_wdata <= 16'h0040;
        ch0_write <= 1'b1;
        @(posedge sys_clk);
        ch0_write <= 1'b0;
        hicount(512);
        hicount(768);
        chk("unbuffered width", 32'(hi), 32'(192));
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            c = 16'(4 + seed[3:0]);
            v = 16'h1 + 16'(seed[7:4]) % (c - 16'h1);
            pwm(3'(i), i[0] ? ELS_SET : ELS_CLEAR, c, v, 1'b0);
        end
        @(posedge sys_clk);
        ctl.stop <= 1'b1;
        ch1_ctl <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        repeat (4) @(posedge sys_clk);
        c = counter;
        ext <= 2'b10;
        repeat (4) @(posedge sys_clk);
        chk("captured value", 32'(ch1_value), 32'(c));
        chk("capture flag", 32'({ch1_flag, ch1_irq}), 32'h3);
        ch1_flag_clear <= 1'b1;
        @(posedge sys_clk);
        ch1_flag_clear <= 1'b0;
        ext <= 2'b00;
        repeat (4) @(negedge sys_clk);
        chk("falling edge ignored", 32'(ch1_flag), 32'h0);
        pwm(3'h0, ELS_CLEAR, 16'h0013, 16'h0005, 1'b0);
        @(posedge sys_clk);
        ch0_ctl.toggle_on_overflow <= 1'b0;
        hicount(40);
        hicount(40);
        chk("zero duty", 32'(hi), 32'h0);
        @(posedge sys_clk);
        ch0_ctl.channel_max_duty <= 1'b1;
        hicount(40);
        hicount(40);
        chk("full duty", 32'(hi), 32'(40));
        // channel 1 on its own: set on compare, no overflow toggle
        @(posedge sys_clk);
        ch1_wdata <= 16'h000a;
        ch1_write <= 1'b1;
        ch1_ctl   <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        @(posedge sys_clk);
        ch1_write <= 1'b0;
        repeat (40) @(negedge sys_clk);
        chk("ch1 compare", 32'({channel1_pin_oe, channel1_pin_out, ch1_flag}), 32'h7);
        chk("ch1 pin level", 32'(pin[1]), 32'h1);
        @(posedge sys_clk);
        ch1_ctl <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        @(posedge sys_clk);
        ch1_flag_clear <= 1'b1;
        @(posedge sys_clk);
        ch1_flag_clear <= 1'b0;
        pwm(3'h0, ELS_CLEAR, 16'h0013, 16'h0005, 1'b1);
        @(posedge sys_clk);
        ext <= 2'b10;
        repeat (4) @(negedge sys_clk);
        chk("released", 32'({released, channel1_pin_oe, pin[1], ch1_flag}), 32'ha);
        @(posedge sys_clk);
        ch1_wdata <= 16'h000c;
        ch1_write <= 1'b1;
        @(posedge sys_clk);
        ch1_write <= 1'b0;
        hicount(40);
        hicount(60);
        chk("linked width", 32'(hi), 32'(36));
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// *** tb/tccpt_pin_model.sv ***
`default_nettype none
module tccpt_pin_model (
    input  wire logic       sys_clk,
    input  wire logic [1:0] ext,
    input  wire logic [1:0] out,
    input  wire logic [1:0] oe,
    output logic [1:0]      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] src;
    // external source is registered so pin levels stay synchronous
    always_ff @(posedge sys_clk) begin
        src <= ext;
    end
    assign pin = (oe & out) | (~oe & src);
endmodule : tccpt_pin_model
`default_nettype wire

// *** tb/tccpt_properties.sv ***
`default_nettype none
module tccpt_properties
    import tccpt_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         reset,
    input wire tccpt_ctl_t   ctl,
    input wire tccpt_chctl_t ch0_ctl,
    input wire logic         overflow_flag_clear,
    input wire logic         ch0_flag_clear,
    input wire logic [15:0]  counter,
    input wire logic         overflow_flag,
    input wire logic         ch0_flag,
    input wire logic         ch0_irq,
    input wire logic         channel1_pin_oe,
    input wire logic         channel1_released
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [15:0] cnt_d;
    logic [15:0] lim_d;
    logic        rst_d;
    logic        wrap;
    // reset folded in so the first edges after release see no stale wrap
    always_ff @(posedge sys_clk) begin
        cnt_d <= counter;
        lim_d <= ctl.counter_limit;
        rst_d <= ctl.counter_reset | reset;
    end
    assign wrap = counter == 16'h0000 && cnt_d == lim_d && cnt_d != 16'h0000 && !rst_d;

    property p_wrap;
        cnt_d == lim_d && !rst_d && counter != cnt_d |-> counter == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at limit");
    property p_up;
        !rst_d && cnt_d != lim_d |-> counter == cnt_d || counter == cnt_d + 16'h0001;
    endproperty
    a_up: assert property (p_up) else $error("counter not counting up by one");
    property p_ovf;
        wrap |-> overflow_flag;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing at wrap");
    property p_stop;
        $past(ctl.stop, 2) && $past(ctl.stop) && !$past(ctl.counter_reset) |-> $stable(counter);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");
    property p_ovf_hold;
        $past(overflow_flag) && !$past(overflow_flag_clear) |-> overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
    property p_ch0_hold;
        $past(ch0_flag) && !$past(ch0_flag_clear) |-> ch0_flag;
    endproperty
    a_ch0_hold: assert property (p_ch0_hold) else $error("channel 0 flag lost");
    property p_irq_on;
        ch0_flag && $past(ch0_flag) && ch0_ctl.int_enable && $past(ch0_ctl.int_enable)
            |-> ch0_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("channel 0 request missing");
    property p_link;
        $past(ch0_ctl.channel_mode_b) |-> channel1_released && !channel1_pin_oe;
    endproperty
    a_link: assert property (p_link) else $error("channel 1 pin not released");
    c_wrap: cover property (wrap);
    c_flag: cover property ($rose(ch0_flag));
    c_link: cover property (channel1_released);
endmodule : tccpt_properties

bind tccpt_timer tccpt_properties u_props (
    .sys_clk(sys_clk), .reset(reset), .ctl(ctl), .ch0_ctl(ch0_ctl),
    .overflow_flag_clear(overflow_flag_clear), .ch0_flag_clear(ch0_flag_clear),
    .counter(counter), .overflow_flag(overflow_flag), .ch0_flag(ch0_flag),
    .ch0_irq(ch0_irq), .channel1_pin_oe(channel1_pin_oe),
    .channel1_released(channel1_released)
);
`default_nettype wire
